// *** common/cmbx_pkg.sv ***
/*
  cmbx_pkg: opcodes, flag positions, cycle counts and layout constants for the
  move/bit/branch execution block.
  assumes: one core clock at 20 MHz, synchronous active-low reset.
*/
`default_nettype none
package cmbx_pkg;
  // instruction operation codes presented by the decoder upstream
  typedef enum logic [4:0] {
    CMBX_OP_NOP      = 5'h00,
    CMBX_OP_BR_VS    = 5'h01,
    CMBX_OP_BR_VC    = 5'h02,
    CMBX_OP_BR_IE    = 5'h03,
    CMBX_OP_BR_ID    = 5'h04,
    CMBX_OP_LD_IND   = 5'h05,
    CMBX_OP_LD_DISP  = 5'h06,
    CMBX_OP_ST_IND   = 5'h07,
    CMBX_OP_ST_DISP  = 5'h08,
    CMBX_OP_LD_DIR   = 5'h09,
    CMBX_OP_ST_DIR   = 5'h0a,
    CMBX_OP_PM_READ  = 5'h0b,
    CMBX_OP_PM_WRITE = 5'h0c,
    CMBX_OP_PUSH     = 5'h0d,
    CMBX_OP_POP      = 5'h0e,
    CMBX_OP_IO_SET   = 5'h0f,
    CMBX_OP_IO_CLR   = 5'h10,
    CMBX_OP_ROL      = 5'h11,
    CMBX_OP_ROR      = 5'h12,
    CMBX_OP_ASR      = 5'h13,
    CMBX_OP_BST      = 5'h14,
    CMBX_OP_BLD      = 5'h15,
    CMBX_OP_FSET     = 5'h16,
    CMBX_OP_FCLR     = 5'h17,
    CMBX_OP_SLEEP    = 5'h18,
    CMBX_OP_WDR      = 5'h19,
    CMBX_OP_BREAK    = 5'h1a
  } cmbx_op_t;

  // pointer update modes
  typedef enum logic [1:0] {
    CMBX_PTR_PLAIN = 2'h0,
    CMBX_PTR_POST  = 2'h1,
    CMBX_PTR_PRE   = 2'h2
  } cmbx_ptr_mode_t;

  // status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam logic [7:0] CMBX_STATUS_FLAGS_RST = 8'h00;
  localparam logic [15:0] CMBX_PC_RST  = 16'h0000;
  localparam logic [15:0] CMBX_SP_RST  = 16'h045f;
  localparam logic [15:0] CMBX_PTR_RST = 16'h0000;

  // cycle counts
  localparam logic [1:0] CMBX_CYC_ONE   = 2'h1;
  localparam logic [1:0] CMBX_CYC_TWO   = 2'h2;
  localparam logic [1:0] CMBX_CYC_THREE = 2'h3;
  // program memory write: held until the memory reports done
  localparam logic [1:0] CMBX_CYC_OPEN  = 2'h0;
endpackage : cmbx_pkg
`default_nettype wire

// *** verilog/cmbx_shift_unit.sv ***
/*
  cmbx_shift_unit: combinational rotate and shift with flag results.
  assumes: op selects one of rotate left, rotate right or arithmetic right.
*/
`default_nettype none
module cmbx_shift_unit (
  input  wire logic [7:0]         value,
  input  wire logic               carry_in,
  input  wire cmbx_pkg::cmbx_op_t op,
  output logic      [7:0]         result,
  output logic                    carry_out,
  output logic                    zero,
  output logic                    negative,
  output logic                    overflow
);
  import cmbx_pkg::*;

  wire is_rol = (op == CMBX_OP_ROL);
  wire is_ror = (op == CMBX_OP_ROR);

  assign result    = is_rol ? {value[6:0], carry_in} :
                     is_ror ? {carry_in, value[7:1]} :
                              {value[7], value[7:1]};
  assign carry_out = is_rol ? value[7] : value[0];
  assign zero      = (result == 8'h00);
  assign negative  = result[7];
  assign overflow  = negative ^ carry_out;
endmodule : cmbx_shift_unit
`default_nettype wire

// *** verilog/cmbx_exec.sv ***
/*
  cmbx_exec: executes branches, loads/stores, program memory access, stack,
  io bit set/clear, shifts, bit transfer and flag set/clear.
  assumes: decoder gives one issue pulse while ready is high; memories answer
  reads combinationally in the cycle the request stands.
*/
`default_nettype none
// What this block does
// - branch to pc+k+1 on overflow state; one cycle, two if taken
// - branch on global interrupt flag state, same target, one or two cycles
// - indirect load takes two cycles; post-increment after, pre-decrement before; flags kept
// - displaced load from second or third pointer plus q, pointer unchanged, two cycles
// - indirect store in two cycles with post-increment or pre-decrement
// - displaced store from second or third pointer plus q, pointer kept, two cycles
// - direct load and store use absolute address, two cycles, flags kept
// - program read via third pointer takes three cycles; r0, any, or post-increment
// - push and pop take two cycles each, flags kept
// - io bit set or clear takes two cycles, other bits kept
// - rotate left through carry, one cycle, updates zero carry negative overflow
// - rotate right through carry, one cycle, updates zero carry negative overflow
// - bit store copies register bit into transfer flag, one cycle
// - bit load copies transfer flag into register bit, one cycle
// - flag set or clear forces one named flag in one cycle
// - break is debug only; nop, sleep, watchdog kick take one cycle
// - program write stores r1:r0 at third pointer, no fixed cycle count
module cmbx_exec (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       clk_en,
  input  wire logic                       issue,
  input  wire cmbx_pkg::cmbx_op_t         op,
  input  wire cmbx_pkg::cmbx_ptr_mode_t   ptr_mode,
  input  wire logic [1:0]                 ptr_sel,
  input  wire logic [5:0]                 disp,
  input  wire logic [15:0]                abs_addr,
  input  wire logic signed [6:0]          offset,
  input  wire logic [2:0]                 bit_sel,
  input  wire logic [4:0]                 reg_idx,
  input  wire logic [7:0]                 reg_val,
  input  wire logic                       r0_form,
  input  wire logic [15:0]                r1r0,
  input  wire logic [7:0]                 dmem_rdata,
  input  wire logic [7:0]                 pmem_rdata,
  input  wire logic                       pmem_wr_done,
  output logic                            ready,
  output logic [15:0]                     pc,
  output logic [7:0]                      status_flags,
  output logic [15:0]                     ptr_x,
  output logic [15:0]                     ptr_y,
  output logic [15:0]                     ptr_z,
  output logic [15:0]                     stack_ptr,
  output logic [15:0]                     dmem_addr,
  output logic                            dmem_rd,
  output logic                            dmem_wr,
  output logic [7:0]                      dmem_wdata,
  output logic [15:0]                     pmem_addr,
  output logic                            pmem_rd,
  output logic                            pmem_wr,
  output logic [15:0]                     pmem_wdata,
  output logic                            rf_we,
  output logic [4:0]                      rf_idx,
  output logic [7:0]                      rf_wdata,
  output logic                            sleep_req,
  output logic                            wdog_kick,
  output logic                            debug_break
);
  import cmbx_pkg::*;

  typedef enum logic [2:0] {
    CMBX_ST_IDLE = 3'b001,
    CMBX_ST_BUSY = 3'b010,
    CMBX_ST_PMW  = 3'b100
  } cmbx_state_t;

  cmbx_state_t state_q;
  logic [1:0]  left_q;
  logic [7:0]  sh_res;
  logic        sh_c;
  logic        sh_z;
  logic        sh_n;
  logic        sh_v;

  cmbx_shift_unit u_shift (
    .value     (reg_val),
    .carry_in  (status_flags[FLAG_C]),
    .op        (op),
    .result    (sh_res),
    .carry_out (sh_c),
    .zero      (sh_z),
    .negative  (sh_n),
    .overflow  (sh_v)
  );

  function automatic logic [15:0] ptr_pick(input logic [1:0] s, input logic [15:0] x,
                                           input logic [15:0] y, input logic [15:0] z);
    ptr_pick = (s == 2'h0) ? x : (s == 2'h1) ? y : z;
  endfunction : ptr_pick

  wire go = clk_en && issue && ready && (state_q == CMBX_ST_IDLE);
  wire is_br = (op == CMBX_OP_BR_VS) || (op == CMBX_OP_BR_VC) ||
               (op == CMBX_OP_BR_IE) || (op == CMBX_OP_BR_ID);
  wire take  = (op == CMBX_OP_BR_VS) ?  status_flags[FLAG_V] :
               (op == CMBX_OP_BR_VC) ? !status_flags[FLAG_V] :
               (op == CMBX_OP_BR_IE) ?  status_flags[FLAG_I] :
               (op == CMBX_OP_BR_ID) ? !status_flags[FLAG_I] : 1'b0;
  wire [15:0] br_target = pc + {{9{offset[6]}}, offset} + 16'h0001;
  wire [15:0] pc_next   = pc + 16'h0001;

  wire is_ld_ind = (op == CMBX_OP_LD_IND);
  wire is_st_ind = (op == CMBX_OP_ST_IND);
  wire is_ind    = is_ld_ind || is_st_ind;
  wire is_disp   = (op == CMBX_OP_LD_DISP) || (op == CMBX_OP_ST_DISP);
  wire is_dir    = (op == CMBX_OP_LD_DIR) || (op == CMBX_OP_ST_DIR);
  wire is_pmr    = (op == CMBX_OP_PM_READ);
  wire is_io     = (op == CMBX_OP_IO_SET) || (op == CMBX_OP_IO_CLR);
  wire is_stack  = (op == CMBX_OP_PUSH) || (op == CMBX_OP_POP);
  wire is_shift  = (op == CMBX_OP_ROL) || (op == CMBX_OP_ROR) || (op == CMBX_OP_ASR);

  wire [1:0]  psel     = is_pmr ? 2'h2 : is_disp ? (ptr_sel == 2'h1 ? 2'h1 : 2'h2) : ptr_sel;
  wire [15:0] ptr_cur  = ptr_pick(psel, ptr_x, ptr_y, ptr_z);
  wire        pre      = is_ind && (ptr_mode == CMBX_PTR_PRE);
  wire        post     = (is_ind || is_pmr) && (ptr_mode == CMBX_PTR_POST);
  wire [15:0] ptr_dec  = ptr_cur - 16'h0001;
  wire [15:0] ptr_new  = pre ? ptr_dec : post ? (ptr_cur + 16'h0001) : ptr_cur;
  wire        ptr_upd  = go && (pre || post);
  wire [15:0] ind_addr = pre ? ptr_dec : ptr_cur;
  wire [15:0] disp_addr = ptr_cur + {10'h000, disp};
  wire [15:0] sp_after_pop = stack_ptr + 16'h0001;
  wire [15:0] mem_addr = is_ind ? ind_addr : is_disp ? disp_addr : is_dir ? abs_addr :
                         (op == CMBX_OP_POP) ? sp_after_pop : is_io ? {11'h000, reg_idx} + 16'h0020 :
                         stack_ptr;
  wire is_load  = is_ld_ind || (op == CMBX_OP_LD_DISP) || (op == CMBX_OP_LD_DIR) || (op == CMBX_OP_POP);
  wire is_store = is_st_ind || (op == CMBX_OP_ST_DISP) || (op == CMBX_OP_ST_DIR) || (op == CMBX_OP_PUSH);
  wire [7:0] bit_mask  = 8'h01 << bit_sel;
  wire [7:0] io_new    = (op == CMBX_OP_IO_SET) ? (dmem_rdata | bit_mask) : (dmem_rdata & ~bit_mask);
  wire [7:0] bld_val   = status_flags[FLAG_T] ? (reg_val | bit_mask) : (reg_val & ~bit_mask);

  wire [1:0] cycles = (is_br && take) ? CMBX_CYC_TWO :
                      (is_ind || is_disp || is_dir || is_stack || is_io) ? CMBX_CYC_TWO :
                      is_pmr ? CMBX_CYC_THREE :
                      CMBX_CYC_ONE;

  wire [7:0] flags_d =
    is_shift ? {status_flags[7:5], sh_n ^ sh_v, sh_v, sh_n, sh_z, sh_c} :
    (op == CMBX_OP_BST)  ? ((status_flags & ~(8'h01 << FLAG_T)) |
                            ({7'h00, reg_val[bit_sel]} << FLAG_T)) :
    (op == CMBX_OP_FSET) ? (status_flags | bit_mask) :
    (op == CMBX_OP_FCLR) ? (status_flags & ~bit_mask) :
    status_flags;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= CMBX_ST_IDLE;
      left_q  <= 2'h0;
    end else if (clk_en) begin
      unique case (state_q)
        CMBX_ST_IDLE: begin
          if (go && op == CMBX_OP_PM_WRITE) begin
            state_q <= CMBX_ST_PMW;
          end else if (go && cycles != CMBX_CYC_ONE) begin
            state_q <= CMBX_ST_BUSY;
            left_q  <= cycles - 2'h1;
          end
        end
        CMBX_ST_BUSY: begin
          left_q <= left_q - 2'h1;
          if (left_q == 2'h1) begin
            state_q <= CMBX_ST_IDLE;
          end
        end
        CMBX_ST_PMW: begin
          if (pmem_wr_done) begin
            state_q <= CMBX_ST_IDLE;
          end
        end
        default: state_q <= CMBX_ST_IDLE;
      endcase
    end
  end

  // ready low while busy; one-cycle ops keep it high
  wire ready_d = (state_q == CMBX_ST_IDLE) ? !(go && (cycles != CMBX_CYC_ONE || op == CMBX_OP_PM_WRITE)) :
                 (state_q == CMBX_ST_BUSY) ? (left_q == 2'h1) : pmem_wr_done;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ready        <= 1'b1;
      pc           <= CMBX_PC_RST;
      status_flags <= CMBX_STATUS_FLAGS_RST;
      stack_ptr    <= CMBX_SP_RST;
    end else if (clk_en) begin
      ready <= ready_d;
      if (go) begin
        pc           <= (is_br && take) ? br_target : pc_next;
        status_flags <= flags_d;
        if (op == CMBX_OP_PUSH) stack_ptr <= stack_ptr - 16'h0001;
        else if (op == CMBX_OP_POP) stack_ptr <= sp_after_pop;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ptr_x <= CMBX_PTR_RST;
      ptr_y <= CMBX_PTR_RST;
      ptr_z <= CMBX_PTR_RST;
    end else if (clk_en && ptr_upd) begin
      if (psel == 2'h0) ptr_x <= ptr_new;
      else if (psel == 2'h1) ptr_y <= ptr_new;
      else ptr_z <= ptr_new;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dmem_addr  <= 16'h0000;
      dmem_rd    <= 1'b0;
      dmem_wr    <= 1'b0;
      dmem_wdata <= 8'h00;
      pmem_addr  <= 16'h0000;
      pmem_rd    <= 1'b0;
      pmem_wr    <= 1'b0;
      pmem_wdata <= 16'h0000;
      rf_we      <= 1'b0;
      rf_idx     <= 5'h00;
      rf_wdata   <= 8'h00;
      sleep_req  <= 1'b0;
      wdog_kick  <= 1'b0;
      debug_break <= 1'b0;
    end else if (clk_en) begin
      dmem_rd     <= go && (is_load || is_io);
      dmem_wr     <= go && is_store;
      pmem_rd     <= go && is_pmr;
      pmem_wr     <= go && (op == CMBX_OP_PM_WRITE);
      sleep_req   <= go && (op == CMBX_OP_SLEEP);
      wdog_kick   <= go && (op == CMBX_OP_WDR);
      debug_break <= go && (op == CMBX_OP_BREAK);
      rf_we       <= 1'b0;
      if (go) begin
        dmem_addr  <= mem_addr;
        dmem_wdata <= reg_val;
        pmem_addr  <= ptr_z;
        pmem_wdata <= r1r0;
        rf_idx     <= (is_pmr && r0_form) ? 5'h00 : reg_idx;
        rf_we      <= is_shift || (op == CMBX_OP_BLD);
        rf_wdata   <= is_shift ? sh_res : bld_val;
      end else if (dmem_rd) begin
        dmem_rd    <= 1'b0;
        if (is_io) begin
          dmem_wr    <= 1'b1;
          dmem_wdata <= io_new;
        end else begin
          rf_we    <= 1'b1;
          rf_wdata <= dmem_rdata;
        end
      end else if (pmem_rd) begin
        pmem_rd  <= 1'b0;
        rf_we    <= 1'b1;
        rf_wdata <= pmem_rdata;
      end
    end
  end

  chk_branch_taken_two: assert property (@(posedge clock) disable iff (!rst_n)
    (go && is_br && take) |=> (!ready ##1 ready)) else $error("taken branch not two cycles");
  chk_branch_target: assert property (@(posedge clock) disable iff (!rst_n)
    (go && is_br && take) |=> (pc == $past(br_target))) else $error("branch target wrong");
  chk_branch_not_taken: assert property (@(posedge clock) disable iff (!rst_n)
    (go && is_br && !take) |=> ready) else $error("untaken branch stalled");
  chk_pm_read_three: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && go && is_pmr) |=> (!ready [*2]) ##1 ready) else $error("program read not three cycles");
  chk_stack_two: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && go && is_stack) |=> $stable(status_flags) ##1 ready) else $error("stack op timing");
  chk_push_sp_down: assert property (@(posedge clock) disable iff (!rst_n)
    (go && op == CMBX_OP_PUSH) |=> (stack_ptr == $past(stack_ptr) - 16'h0001)) else $error("push sp");
  sequence s_io_rmw;
    dmem_rd ##1 dmem_wr;
  endsequence : s_io_rmw

  chk_io_writeback: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && go && is_io) |=> s_io_rmw) else $error("io bit writeback missing");
  chk_pre_dec_addr: assert property (@(posedge clock) disable iff (!rst_n)
    (go && pre) |=> (dmem_addr == $past(ptr_cur) - 16'h0001)) else $error("pre-decrement address");
  chk_rol_result: assert property (@(posedge clock) disable iff (!rst_n)
    (go && op == CMBX_OP_ROL) |=> (rf_we && rf_wdata == {$past(reg_val[6:0]), $past(status_flags[FLAG_C])}))
    else $error("rotate left result");
  chk_ror_result: assert property (@(posedge clock) disable iff (!rst_n)
    (go && op == CMBX_OP_ROR) |=> (rf_we && rf_wdata == {$past(status_flags[FLAG_C]), $past(reg_val[7:1])}))
    else $error("rotate right result");
  chk_asr_msb_kept: assert property (@(posedge clock) disable iff (!rst_n)
    (go && op == CMBX_OP_ASR) |=> (rf_we && rf_wdata == {$past(reg_val[7]), $past(reg_val[7:1])}))
    else $error("arithmetic shift result");
  chk_bst_only_t: assert property (@(posedge clock) disable iff (!rst_n)
    (go && op == CMBX_OP_BST) |=> (status_flags[FLAG_T] == $past(reg_val[bit_sel])) &&
    ((status_flags | (8'h01 << FLAG_T)) == ($past(status_flags) | (8'h01 << FLAG_T))))
    else $error("bit store flags");
  chk_flag_set_one: assert property (@(posedge clock) disable iff (!rst_n)
    (go && op == CMBX_OP_FSET) |=> (status_flags == ($past(status_flags) | $past(bit_mask))))
    else $error("flag set wrong");
  chk_disp_ptr_kept: assert property (@(posedge clock) disable iff (!rst_n)
    (go && is_disp) |=> ($stable(ptr_y) && $stable(ptr_z))) else $error("displaced access moved pointer");
  chk_pmw_waits: assert property (@(posedge clock) disable iff (!rst_n)
    (state_q == CMBX_ST_PMW && !pmem_wr_done) |=> !ready) else $error("program write ended early");
endmodule : cmbx_exec
`default_nettype wire

// *** test/cmbx_mem_model.sv ***
/*
  cmbx_mem_model: data and program memory beside the execution block.
  assumes: shares the block's clock; reads answer while the strobe stands and hold one cycle more.
*/
`default_nettype none
module cmbx_mem_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [15:0] dmem_addr,
  input  wire logic        dmem_rd,
  input  wire logic        dmem_wr,
  input  wire logic [7:0]  dmem_wdata,
  input  wire logic [15:0] pmem_addr,
  input  wire logic        pmem_rd,
  input  wire logic        pmem_wr,
  input  wire logic [3:0]  done_wait,
  output logic      [7:0]  dmem_rdata,
  output logic      [7:0]  pmem_rdata,
  output logic             pmem_wr_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem_q [0:65535];
  logic [7:0]  dlast_q = 8'h00;
  logic [7:0]  plast_q = 8'h00;
  logic        drd_q   = 1'b0;
  logic        prd_q   = 1'b0;
  logic        busy_q  = 1'b0;
  logic [3:0]  wait_q  = 4'h0;
  logic [7:0]  pm_byte;
  initial begin
    for (int i = 0; i < 65536; i++) mem_q[i] = i[7:0] ^ i[15:8] ^ 8'h3c;
  end
  assign pm_byte = ~(pmem_addr[7:0] ^ {pmem_addr[14:8], pmem_addr[15]});
  // after the hold cycle the lines show the inverse, never a stale copy
  assign dmem_rdata = dmem_rd ? mem_q[dmem_addr] : (drd_q ? dlast_q : ~dlast_q);
  assign pmem_rdata = pmem_rd ? pm_byte : (prd_q ? plast_q : ~plast_q);
  always @(posedge clock) begin
    drd_q <= dmem_rd;
    prd_q <= pmem_rd;
    pmem_wr_done <= 1'b0;
    if (dmem_rd) dlast_q <= mem_q[dmem_addr];
    if (pmem_rd) plast_q <= pm_byte;
    if (dmem_wr) mem_q[dmem_addr] <= dmem_wdata;
    if (!rst_n) begin
      busy_q <= 1'b0;
      wait_q <= 4'h0;
    end else if (pmem_wr) begin
      busy_q <= 1'b1;
      wait_q <= done_wait;
    end else if (busy_q && wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else if (busy_q) begin
      busy_q       <= 1'b0;
      pmem_wr_done <= 1'b1;
    end
  end
endmodule : cmbx_mem_model
`default_nettype wire

// *** test/cmbx_exec_tb.sv ***
/*
  cmbx_exec_tb: self-checking bench for the execution block.
  assumes: cmbx_mem_model answers the memory side.
*/
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin bad_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module cmbx_exec_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cmbx_pkg::*;
  typedef struct {logic [2:0] k; logic [15:0] a; logic [15:0] d;} cmbx_note_t;
  logic clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, issue = 1'b0, r0_form = 1'b0;
  cmbx_op_t op = CMBX_OP_NOP;
  cmbx_ptr_mode_t ptr_mode = CMBX_PTR_PLAIN;
  logic [1:0] ptr_sel = 2'h0;
  logic [5:0] disp = 6'h00;
  logic [15:0] abs_addr = 16'h0000, r1r0 = 16'h0000;
  logic signed [6:0] offset = 7'h00;
  logic [2:0] bit_sel = 3'h0;
  logic [4:0] reg_idx = 5'h00, rf_idx;
  logic [7:0] reg_val = 8'h00, dmem_rdata, pmem_rdata, status_flags, dmem_wdata, rf_wdata;
  logic [3:0] done_wait = 4'h0;
  logic pmem_wr_done, ready, dmem_rd, dmem_wr, pmem_rd, pmem_wr, rf_we, sleep_req, wdog_kick, debug_break;
  logic [15:0] pc, ptr_x, ptr_y, ptr_z, stack_ptr, dmem_addr, pmem_addr, pmem_wdata;
  cmbx_note_t notes[$];
  logic [7:0] shadow [logic [15:0]];
  logic [15:0] pt [3] = '{16'h0, 16'h0, 16'h0};
  logic [15:0] sp = 16'h045f;
  logic [7:0] fl = 8'h00;
  logic [31:0] rnd = 32'h61075965;
  int bad_count = 0, checked = 0;
  always #25 clock = ~clock;
  cmbx_exec i_cmbx_exec (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .issue(issue), .op(op),
    .ptr_mode(ptr_mode), .ptr_sel(ptr_sel), .disp(disp), .abs_addr(abs_addr), .offset(offset),
    .bit_sel(bit_sel), .reg_idx(reg_idx), .reg_val(reg_val), .r0_form(r0_form), .r1r0(r1r0),
    .dmem_rdata(dmem_rdata), .pmem_rdata(pmem_rdata), .pmem_wr_done(pmem_wr_done), .ready(ready),
    .pc(pc), .status_flags(status_flags), .ptr_x(ptr_x), .ptr_y(ptr_y), .ptr_z(ptr_z),
    .stack_ptr(stack_ptr), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .dmem_wr(dmem_wr),
    .dmem_wdata(dmem_wdata), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .pmem_wr(pmem_wr),
    .pmem_wdata(pmem_wdata), .rf_we(rf_we), .rf_idx(rf_idx), .rf_wdata(rf_wdata),
    .sleep_req(sleep_req), .wdog_kick(wdog_kick), .debug_break(debug_break));
  cmbx_mem_model i_cmbx_mem_model (.clock(clock), .rst_n(rst_n), .dmem_addr(dmem_addr),
    .dmem_rd(dmem_rd), .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata), .pmem_addr(pmem_addr),
    .pmem_rd(pmem_rd), .pmem_wr(pmem_wr), .done_wait(done_wait), .dmem_rdata(dmem_rdata),
    .pmem_rdata(pmem_rdata), .pmem_wr_done(pmem_wr_done));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] dm(input logic [15:0] a);
    return shadow.exists(a) ? shadow[a] : (a[7:0] ^ a[15:8] ^ 8'h3c);
  endfunction : dm
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic note(input logic [2:0] k, input logic [15:0] a, input logic [15:0] d);
    notes.push_back('{k, a, d});
    if (k == 3'h1) shadow[a] = d[7:0];
  endtask : note
  task automatic go(input cmbx_op_t o, input int cyc);
    int n;
    n = 1;
    op <= o;
    issue <= 1'b1;
    @(posedge clock);
    issue <= 1'b0;
    @(negedge clock);
    while (ready !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    if (cyc > 0) `CHK("cycles", cyc, n)
    `CHK("flags", fl, status_flags)
    `CHK("ptr_x", pt[0], ptr_x)
    `CHK("ptr_y", pt[1], ptr_y)
    `CHK("ptr_z", pt[2], ptr_z)
    `CHK("stack_ptr", sp, stack_ptr)
    @(posedge clock);
  endtask : go
  task automatic mv(input logic st, input logic [15:0] a, input cmbx_op_t o);
    rnd = lfsr(rnd);
    reg_val <= rnd[7:0];
    reg_idx <= rnd[12:8];
    if (st) note(3'h1, a, {8'h0, rnd[7:0]});
    else note(3'h0, {11'h0, rnd[12:8]}, {8'h0, dm(a)});
    go(o, 2);
  endtask : mv
  task automatic take(input logic [2:0] k, input logic [15:0] a, input logic [15:0] d);
    cmbx_note_t e;
    if (notes.size() == 0) begin
      `CHK("spare strobe", 3'h7, k)
    end else begin
      e = notes.pop_front();
      `CHK("kind", e.k, k)
      `CHK("where", e.a, a)
      `CHK("value", e.d, d)
    end
  endtask : take
  // scoreboard: every register write, memory write, sleep, watchdog or break strobe takes the oldest note; read strobes take none
  always @(posedge clock) begin
    if (rst_n === 1'b1) begin
      if (rf_we === 1'b1) take(3'h0, {11'h0, rf_idx}, {8'h0, rf_wdata});
      if (dmem_wr === 1'b1) take(3'h1, dmem_addr, {8'h0, dmem_wdata});
      if (pmem_wr === 1'b1) take(3'h2, pmem_addr, pmem_wdata);
      if (sleep_req === 1'b1) take(3'h3, 16'h0, 16'h0);
      if (wdog_kick === 1'b1) take(3'h4, 16'h0, 16'h0);
      if (debug_break === 1'b1) take(3'h5, 16'h0, 16'h0);
    end
  end
  initial begin
    #(50 * 4000);
    bad_count++;
    give_verdict();
  end
  initial begin
    int i, s, m;
    logic [7:0] v;
    logic [15:0] a;
    logic c, st, tk;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    `CHK("ready", 1'b1, ready)
    `CHK("stack_ptr", 16'h045f, stack_ptr)
    @(posedge clock);
    for (i = 0; i < 8; i++) begin
      bit_sel <= i[2:0];
      fl[i] = 1'b1;
      go(CMBX_OP_FSET, 1);
      fl[i] = 1'b0;
      go(CMBX_OP_FCLR, 1);
    end
    for (i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      a = i[1] ? FLAG_I : FLAG_V;
      bit_sel <= a[2:0];
      fl[a[2:0]] = rnd[0];
      go(rnd[0] ? CMBX_OP_FSET : CMBX_OP_FCLR, 1);
      tk = rnd[0] ^ i[0];
      offset <= $signed(rnd[14:8]);
      a = pc + (tk ? {{9{rnd[14]}}, rnd[14:8]} + 16'h1 : 16'h1);
      go(i[1] ? (i[0] ? CMBX_OP_BR_ID : CMBX_OP_BR_IE) : (i[0] ? CMBX_OP_BR_VC : CMBX_OP_BR_VS), tk ? 2 : 1);
      `CHK("pc", a, pc)
    end
    for (i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      v = rnd[7:0];
      c = fl[FLAG_C];
      case (i % 3)
        0: a[7:0] = {v[6:0], c};
        1: a[7:0] = {c, v[7:1]};
        default: a[7:0] = {v[7], v[7:1]};
      endcase
      fl[FLAG_C] = (i % 3 == 0) ? v[7] : v[0];
      fl[FLAG_Z] = (a[7:0] == 8'h00);
      fl[FLAG_N] = a[7];
      fl[FLAG_V] = a[7] ^ fl[FLAG_C];
      fl[FLAG_S] = fl[FLAG_N] ^ fl[FLAG_V];
      reg_val <= v;
      reg_idx <= rnd[12:8];
      note(3'h0, {11'h0, rnd[12:8]}, {8'h0, a[7:0]});
      go(i % 3 == 0 ? CMBX_OP_ROL : (i % 3 == 1 ? CMBX_OP_ROR : CMBX_OP_ASR), 1);
    end
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      bit_sel <= i[2:0];
      reg_val <= rnd[7:0];
      fl[FLAG_T] = rnd[i];
      go(CMBX_OP_BST, 1);
      go(CMBX_OP_NOP, 1);
      rnd = lfsr(rnd);
      a = {8'h0, rnd[23:16]};
      a[i] = fl[FLAG_T];
      reg_val <= rnd[23:16];
      reg_idx <= rnd[12:8];
      note(3'h0, {11'h0, rnd[12:8]}, a);
      go(CMBX_OP_BLD, 1);
    end
    for (i = 0; i < 18; i++) begin
      s = i % 3;
      m = (i / 3) % 3;
      st = i >= 9;
      ptr_sel <= s[1:0];
      ptr_mode <= cmbx_ptr_mode_t'(m[1:0]);
      if (m == 2) pt[s] = pt[s] - 16'h1;
      a = pt[s];
      if (m == 1) pt[s] = pt[s] + 16'h1;
      mv(st, a, st ? CMBX_OP_ST_IND : CMBX_OP_LD_IND);
    end
    ptr_mode <= CMBX_PTR_PLAIN;
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      if (i < 4) begin
        ptr_sel <= i[0] ? 2'h2 : 2'h1;
        disp <= rnd[5:0];
        a = pt[i[0] ? 2 : 1] + {10'h0, rnd[5:0]};
      end else if (!i[0]) a = rnd[31:16];
      abs_addr <= a;
      st = (i < 4) ? i[1] : !i[0];
      mv(st, a, i < 4 ? (st ? CMBX_OP_ST_DISP : CMBX_OP_LD_DISP) : (st ? CMBX_OP_ST_DIR : CMBX_OP_LD_DIR));
    end
    for (i = 0; i < 6; i++) begin
      a = sp;
      if (i < 3) sp = sp - 16'h1;
      else sp = sp + 16'h1;
      mv(i < 3, i < 3 ? a : sp, i < 3 ? CMBX_OP_PUSH : CMBX_OP_POP);
    end
    for (i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      reg_idx <= rnd[4:0];
      bit_sel <= rnd[10:8];
      a = 16'h20 + {11'h0, rnd[4:0]};
      v = dm(a);
      v[rnd[10:8]] = i[0];
      note(3'h1, a, {8'h0, v});
      go(i[0] ? CMBX_OP_IO_SET : CMBX_OP_IO_CLR, 2);
    end
    ptr_sel <= 2'h2;
    for (i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      r0_form <= (i == 0);
      reg_idx <= rnd[4:0];
      ptr_mode <= (i == 2) ? CMBX_PTR_POST : CMBX_PTR_PLAIN;
      a = pt[2];
      note(3'h0, (i == 0) ? 16'h0 : {11'h0, rnd[4:0]}, {8'h0, ~(a[7:0] ^ {a[14:8], a[15]})});
      if (i == 2) pt[2] = pt[2] + 16'h1;
      go(CMBX_OP_PM_READ, 3);
      r1r0 <= rnd[31:16];
      done_wait <= i[0] ? 4'h5 : 4'h0;
      note(3'h2, pt[2], rnd[31:16]);
      go(CMBX_OP_PM_WRITE, 0);
    end
    note(3'h3, 16'h0, 16'h0);
    go(CMBX_OP_SLEEP, 1);
    note(3'h4, 16'h0, 16'h0);
    go(CMBX_OP_WDR, 1);
    note(3'h5, 16'h0, 16'h0);
    go(CMBX_OP_BREAK, 0);
    go(CMBX_OP_NOP, 1);
    issue <= 1'b0;
    repeat (4) @(posedge clock);
    `CHK("notes left", 0, notes.size())
    give_verdict();
  end
endmodule : cmbx_exec_tb
`default_nettype wire
